// file: rtl/hfm_defs.svh
// Constants for the heater fault current monitor: offsets, fields, resets, timing
`ifndef HFM_DEFS_SVH
`define HFM_DEFS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define HFM_OFS_CONFIG 8'h00
`define HFM_OFS_SETPOINT_ONE 8'h04
`define HFM_OFS_SETPOINT_TWO 8'h08
`define HFM_OFS_MARGIN_ONE 8'h0C
`define HFM_OFS_MARGIN_TWO 8'h10
`define HFM_OFS_DELAY 8'h14
`define HFM_OFS_STATUS 8'h18
`define HFM_OFS_MASK 8'h1C
`define HFM_OFS_STATE 8'h20

// ---------------------------------------------------------------
// Field codes and limits (tenths of an ampere or of a percent)
// ---------------------------------------------------------------
`define HFM_ASG_NONE 2'h0
`define HFM_ASG_OUT_ONE 2'h1
`define HFM_ASG_OUT_TWO 2'h2
`define HFM_FULL_SCALE 10'h3E8
`define HFM_SMALL_SENSOR_MAX 10'h12C
`define HFM_MARGIN_HIGH_LSB 16
`define HFM_RESP_OKAY 2'h0
`define HFM_RESP_SLVERR 2'h2

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define HFM_SETPOINT_RST 10'h000
`define HFM_MARGIN_RST 10'h12C
`define HFM_DELAY_RST 8'h03
`define HFM_ASG_ONE_RST 2'h1
`define HFM_ASG_TWO_RST 2'h0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define HFM_CLK_HZ 10000000
`define HFM_SETUP_TIMEOUT_S 60
`define HFM_SETUP_TIMEOUT_CYC (`HFM_SETUP_TIMEOUT_S * `HFM_CLK_HZ)

`endif

// file: rtl/hfm_pkg.sv
// Types shared by the heater fault current monitor
package hfm_pkg;

   // ------------------------------------------------------------
   // Setup display mode, one-hot
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      HFM_ST_MONITOR = 2'b01,
      HFM_ST_SETUP = 2'b10
   } hfm_mode_t;

   // ------------------------------------------------------------
   // Configuration word, laid out as the CONFIG register
   // ------------------------------------------------------------
   typedef struct packed {
      logic large_sensor;
      logic dout_sel;
      logic control_output_two_fit;
      logic [1:0] type_b;
      logic [1:0][1:0] asg;
   } hfm_cfg_t;

   // ------------------------------------------------------------
   // One sample of the sensors and control outputs
   // ------------------------------------------------------------
   typedef struct packed {
      logic valid;
      logic [1:0][9:0] load_current_sensor;
      logic [1:0][9:0] manipulated_output;
      logic [1:0] control_output_on;
   } hfm_sample_t;

   // ------------------------------------------------------------
   // AXI4-Lite channels
   // ------------------------------------------------------------
   typedef struct packed {
      logic awvalid;
      logic [7:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [7:0] araddr;
      logic rready;
   } hfm_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } hfm_axi_rsp_t;

   typedef struct packed {
      logic ok;
      logic [31:0] data;
   } hfm_rd_t;

   // ------------------------------------------------------------
   // Whole state of the monitor
   // ------------------------------------------------------------
   typedef struct packed {
      hfm_mode_t mode;
      logic [29:0] idle_cnt;
      logic strap_done;
      hfm_cfg_t cfg;
      logic [1:0][9:0] sp;
      logic [1:0][9:0] lowp;
      logic [1:0][9:0] highp;
      logic [1:0][7:0] delay;
      logic [1:0][7:0] cnt;
      logic [1:0] alarm;
      logic [1:0] alarm_out;
      logic [1:0] sts;
      logic [1:0] mask;
      logic irq;
      logic aw_have;
      logic [7:0] waddr;
      logic w_have;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      hfm_axi_rsp_t axi;
   } hfm_state_t;

endpackage : hfm_pkg

// file: rtl/hfm_monitor.sv
// Two-channel heater fault current monitor with AXI4-Lite registers
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "hfm_defs.svh"

module hfm_monitor #(
   parameter int unsigned SETUP_TIMEOUT_CYC = `HFM_SETUP_TIMEOUT_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire hfm_pkg::hfm_axi_req_t axi_req,
   output var hfm_pkg::hfm_axi_rsp_t axi_rsp,
   input wire hfm_pkg::hfm_sample_t sample,
   input wire logic out_one_continuous,
   input wire logic setup_enter,
   input wire logic key_press,
   output logic heater_fault_alarm_one,
   output logic heater_fault_alarm_two,
   output logic setup_mode_active,
   output logic irq
);

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   // Scale a by b per thousand; product never exceeds 20 bits
   function automatic logic [10:0] hfm_scale(input logic [9:0] a,
                                             input logic [9:0] b);
      logic [19:0] p;
      p = 20'(a) * 20'(b);
      return 11'(p / 20'(`HFM_FULL_SCALE));
   endfunction : hfm_scale

   function automatic logic hfm_assigned(input logic [1:0] asg);
      return (asg == `HFM_ASG_OUT_ONE) || (asg == `HFM_ASG_OUT_TWO);
   endfunction : hfm_assigned

   function automatic logic [9:0] hfm_clamp(input logic [9:0] v);
      return (v > `HFM_FULL_SCALE) ? `HFM_FULL_SCALE : v;
   endfunction : hfm_clamp

   function automatic logic [31:0] hfm_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
      logic [31:0] r;
      r = old_v;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            r[8*b +: 8] = new_v[8*b +: 8];
         end
      end
      return r;
   endfunction : hfm_merge

   // Shared by bus reads and by byte-lane merging of writes
   function automatic hfm_pkg::hfm_rd_t hfm_read(
      input hfm_pkg::hfm_state_t s, input logic [7:0] addr);
      hfm_pkg::hfm_rd_t r;
      logic [1:0] vis;
      r.ok = 1'b1;
      r.data = 32'h0000_0000;
      vis[0] = hfm_assigned(s.cfg.asg[0]);
      vis[1] = hfm_assigned(s.cfg.asg[1]);
      case (addr)
         `HFM_OFS_CONFIG: r.data[8:0] = s.cfg;
         // Hidden parameters read as zero
         `HFM_OFS_SETPOINT_ONE: r.data[9:0] = vis[0] ? s.sp[0] : 10'h000;
         `HFM_OFS_SETPOINT_TWO: r.data[9:0] = vis[1] ? s.sp[1] : 10'h000;
         `HFM_OFS_MARGIN_ONE: begin
            if (vis[0] && s.cfg.type_b[0]) begin
               r.data[9:0] = s.lowp[0];
               r.data[`HFM_MARGIN_HIGH_LSB +: 10] = s.highp[0];
            end
         end
         `HFM_OFS_MARGIN_TWO: begin
            if (vis[1] && s.cfg.type_b[1]) begin
               r.data[9:0] = s.lowp[1];
               r.data[`HFM_MARGIN_HIGH_LSB +: 10] = s.highp[1];
            end
         end
         `HFM_OFS_DELAY: r.data[15:0] = s.delay;
         `HFM_OFS_STATUS: r.data[1:0] = s.sts;
         `HFM_OFS_MASK: r.data[1:0] = s.mask;
         `HFM_OFS_STATE: begin
            r.data[1:0] = s.alarm;
            r.data[3:2] = vis;
            r.data[5:4] = vis & s.cfg.type_b;
            r.data[6] = (s.mode == hfm_pkg::HFM_ST_SETUP);
            r.data[23:16] = s.cnt[0];
            r.data[31:24] = s.cnt[1];
         end
         default: r.ok = 1'b0;
      endcase
      return r;
   endfunction : hfm_read

   // ------------------------------------------------------------
   // Reset state
   // ------------------------------------------------------------
   localparam hfm_pkg::hfm_state_t HFM_RST = '{
      mode: hfm_pkg::HFM_ST_MONITOR,
      idle_cnt: 30'h0000_0000,
      strap_done: 1'b0,
      cfg: {5'h00, `HFM_ASG_TWO_RST, `HFM_ASG_ONE_RST},
      sp: {2{`HFM_SETPOINT_RST}},
      lowp: {2{`HFM_MARGIN_RST}},
      highp: {2{`HFM_MARGIN_RST}},
      delay: {2{`HFM_DELAY_RST}},
      cnt: 16'h0000,
      alarm: 2'h0, alarm_out: 2'h0, sts: 2'h0, mask: 2'h0, irq: 1'b0,
      aw_have: 1'b0, waddr: 8'h00, w_have: 1'b0, wdata: 32'h0000_0000,
      wstrb: 4'h0,
      axi: '0
   };

   hfm_pkg::hfm_state_t s_q;
   hfm_pkg::hfm_state_t s_d;
   logic [1:0] act_c;
   logic [1:0] fault_c;
   logic [1:0] flo_c;
   logic [1:0] fhi_c;
   logic [1:0] fa_c;

   // ------------------------------------------------------------
   // Per-channel fault evaluation
   // ------------------------------------------------------------
   for (genvar gi = 0; gi < 2; gi++) begin : g_ch
      logic use_two;
      logic on_c;
      logic [9:0] mv_c;
      logic [9:0] cur_c;
      logic [10:0] exp_c;
      logic [10:0] lw_c;
      logic [10:0] hw_c;
      logic signed [12:0] lo_th;
      logic signed [12:0] hi_th;
      logic signed [12:0] cur_s;
      // Sensor gi always feeds channel gi; output is selectable
      assign cur_c = sample.load_current_sensor[gi];
      assign use_two = (s_q.cfg.asg[gi] == `HFM_ASG_OUT_TWO);
      assign on_c = sample.control_output_on[use_two];
      assign mv_c = sample.manipulated_output[use_two];
      // Off setpoint or no output disables the channel
      assign act_c[gi] = hfm_assigned(s_q.cfg.asg[gi]) &&
                         (s_q.sp[gi] != 10'h000);
      assign fa_c[gi] = on_c ? (cur_c <= s_q.sp[gi])
                             : (cur_c >= s_q.sp[gi]);
      assign exp_c = hfm_scale(s_q.sp[gi], mv_c);
      assign lw_c = hfm_scale(s_q.lowp[gi], s_q.sp[gi]);
      assign hw_c = hfm_scale(s_q.highp[gi], s_q.sp[gi]);
      // Signed so a threshold below zero can never be met
      assign lo_th = $signed({2'b00, exp_c}) - $signed({2'b00, lw_c});
      assign hi_th = $signed({2'b00, exp_c}) + $signed({2'b00, hw_c});
      assign cur_s = $signed({3'b000, cur_c});
      assign flo_c[gi] = (s_q.lowp[gi] != 10'h000) && (cur_s <= lo_th);
      assign fhi_c[gi] = (s_q.highp[gi] != 10'h000) && (cur_s >= hi_th);
      assign fault_c[gi] = act_c[gi] && (s_q.cfg.type_b[gi]
                           ? (flo_c[gi] || fhi_c[gi]) : fa_c[gi]);
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      hfm_pkg::hfm_rd_t rd;
      logic [31:0] wv;
      logic [31:0] wmask;
      logic [7:0] preset;
      logic [7:0] nxt;
      logic [1:0] vis;
      logic [1:0] rise;
      s_d = s_q;
      rd = '0;
      wv = 32'h0000_0000;
      wmask = 32'h0000_0000;
      preset = 8'h00;
      nxt = 8'h00;
      rise = 2'h0;
      vis[0] = hfm_assigned(s_q.cfg.asg[0]);
      vis[1] = hfm_assigned(s_q.cfg.asg[1]);

      // Output kind strap is caught once, the first cycle after reset
      if (!s_q.strap_done) begin
         s_d.strap_done = 1'b1;
         s_d.cfg.type_b[0] = out_one_continuous;
         s_d.axi.awready = 1'b1;
         s_d.axi.wready = 1'b1;
         s_d.axi.arready = 1'b1;
      end

      // Address and data are taken independently, in either order
      if (axi_req.awvalid && s_q.axi.awready) begin
         s_d.aw_have = 1'b1;
         s_d.waddr = axi_req.awaddr;
         s_d.axi.awready = 1'b0;
      end
      if (axi_req.wvalid && s_q.axi.wready) begin
         s_d.w_have = 1'b1;
         s_d.wdata = axi_req.wdata;
         s_d.wstrb = axi_req.wstrb;
         s_d.axi.wready = 1'b0;
      end
      if (s_q.axi.bvalid && axi_req.bready) begin
         s_d.axi.bvalid = 1'b0;
         s_d.axi.awready = 1'b1;
         s_d.axi.wready = 1'b1;
      end

      // Register write once both halves are held
      if (s_q.aw_have && s_q.w_have && !s_q.axi.bvalid) begin
         rd = hfm_read(s_q, s_q.waddr);
         wv = hfm_merge(rd.data, s_q.wdata, s_q.wstrb);
         wmask = hfm_merge(32'h0000_0000, 32'hFFFF_FFFF, s_q.wstrb);
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.axi.bvalid = 1'b1;
         s_d.axi.bresp = rd.ok ? `HFM_RESP_OKAY : `HFM_RESP_SLVERR;
         case (s_q.waddr)
            `HFM_OFS_CONFIG: s_d.cfg = wv[8:0];
            // Writes to hidden parameters are dropped
            `HFM_OFS_SETPOINT_ONE: if (vis[0])
               s_d.sp[0] = hfm_clamp(wv[9:0]);
            `HFM_OFS_SETPOINT_TWO: if (vis[1])
               s_d.sp[1] = hfm_clamp(wv[9:0]);
            `HFM_OFS_MARGIN_ONE: begin
               if (vis[0] && s_q.cfg.type_b[0]) begin
                  s_d.lowp[0] = hfm_clamp(wv[9:0]);
                  s_d.highp[0] = hfm_clamp(wv[25:16]);
               end
            end
            `HFM_OFS_MARGIN_TWO: begin
               if (vis[1] && s_q.cfg.type_b[1]) begin
                  s_d.lowp[1] = hfm_clamp(wv[9:0]);
                  s_d.highp[1] = hfm_clamp(wv[25:16]);
               end
            end
            `HFM_OFS_DELAY: s_d.delay = wv[15:0];
            `HFM_OFS_STATUS: s_d.sts = s_q.sts & ~(s_q.wdata[1:0] & wmask[1:0]);
            `HFM_OFS_MASK: s_d.mask = wv[1:0];
            default: s_d.cfg = s_q.cfg;
         endcase
      end

      // Reads answer one cycle after the address is taken
      if (axi_req.arvalid && s_q.axi.arready) begin
         rd = hfm_read(s_q, axi_req.araddr);
         s_d.axi.arready = 1'b0;
         s_d.axi.rvalid = 1'b1;
         s_d.axi.rdata = rd.data;
         s_d.axi.rresp = rd.ok ? `HFM_RESP_OKAY : `HFM_RESP_SLVERR;
      end
      if (s_q.axi.rvalid && axi_req.rready) begin
         s_d.axi.rvalid = 1'b0;
         s_d.axi.arready = 1'b1;
      end

      // Setup display timeout; any key restarts the minute
      case (s_q.mode)
         hfm_pkg::HFM_ST_MONITOR: begin
            s_d.idle_cnt = 30'h0000_0000;
            if (setup_enter) begin
               s_d.mode = hfm_pkg::HFM_ST_SETUP;
            end
         end
         hfm_pkg::HFM_ST_SETUP: begin
            if (key_press) begin
               s_d.idle_cnt = 30'h0000_0000;
            end else if (s_q.idle_cnt >= 30'(SETUP_TIMEOUT_CYC - 1)) begin
               s_d.mode = hfm_pkg::HFM_ST_MONITOR;
               s_d.idle_cnt = 30'h0000_0000;
            end else begin
               s_d.idle_cnt = 30'(s_q.idle_cnt + 30'h0000_0001);
            end
         end
         default: s_d.mode = hfm_pkg::HFM_ST_MONITOR;
      endcase

      // Consecutive-sample runs per channel
      for (int i = 0; i < 2; i++) begin
         preset = (s_q.delay[i] == 8'h00) ? 8'h01 : s_q.delay[i];
         if (!act_c[i]) begin
            s_d.cnt[i] = 8'h00;
            s_d.alarm[i] = 1'b0;
         end else if (sample.valid) begin
            if (fault_c[i]) begin
               nxt = (s_q.cnt[i] >= preset) ? preset
                                            : 8'(s_q.cnt[i] + 8'h01);
               s_d.cnt[i] = nxt;
               s_d.alarm[i] = (nxt >= preset);
            end else begin
               s_d.cnt[i] = 8'h00;
               s_d.alarm[i] = 1'b0;
            end
         end
         rise[i] = s_d.alarm[i] && !s_q.alarm[i];
      end

      // Set after the clear so a new event is never lost
      s_d.sts = s_d.sts | rise;
      s_d.alarm_out = s_d.alarm &
                      {2{s_d.cfg.control_output_two_fit || s_d.cfg.dout_sel}};
      s_d.irq = |(s_d.sts & s_d.mask);
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= HFM_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from the state register
   assign axi_rsp = s_q.axi;
   assign heater_fault_alarm_one = s_q.alarm_out[0];
   assign heater_fault_alarm_two = s_q.alarm_out[1];
   assign setup_mode_active = (s_q.mode == hfm_pkg::HFM_ST_SETUP);
   assign irq = s_q.irq;

   // ------------------------------------------------------------
   // Assertions and covers
   // ------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   AST_HIDDEN_READS_ZERO: assert property (
      axi_req.arvalid && s_q.axi.arready &&
      axi_req.araddr == `HFM_OFS_SETPOINT_TWO &&
      !hfm_assigned(s_q.cfg.asg[1]) |=> axi_rsp.rvalid &&
      axi_rsp.rdata == 32'h0000_0000)
      else $error("hidden setpoint did not read as zero");
   AST_NO_OUTPUT_UNFITTED: assert property (
      heater_fault_alarm_one || heater_fault_alarm_two |->
      s_q.cfg.control_output_two_fit || s_q.cfg.dout_sel)
      else $error("alarm driven with no output fitted");
   AST_SETPOINT_LIMIT: assert property (
      s_q.sp[0] <= `HFM_FULL_SCALE && s_q.sp[1] <= `HFM_FULL_SCALE)
      else $error("setpoint above full scale");
   // Last sample of a run: count plus one reaches the preset
   AST_TYPEA_LOW: assert property (
      sample.valid && act_c[0] && !s_q.cfg.type_b[0] &&
      sample.control_output_on[s_q.cfg.asg[0] == `HFM_ASG_OUT_TWO] &&
      sample.load_current_sensor[0] <= s_q.sp[0] &&
      9'(s_q.cnt[0]) + 9'h001 >= 9'(s_q.delay[0]) |=> s_q.alarm[0])
      else $error("type A low current alarm missed");
   AST_TYPEA_HIGH: assert property (
      sample.valid && act_c[0] && !s_q.cfg.type_b[0] &&
      !sample.control_output_on[s_q.cfg.asg[0] == `HFM_ASG_OUT_TWO] &&
      sample.load_current_sensor[0] >= s_q.sp[0] &&
      9'(s_q.cnt[0]) + 9'h001 >= 9'(s_q.delay[0]) |=> s_q.alarm[0])
      else $error("type A high current alarm missed");
   AST_TYPEB_LOW: assert property (
      sample.valid && act_c[0] && s_q.cfg.type_b[0] && flo_c[0] &&
      9'(s_q.cnt[0]) + 9'h001 >= 9'(s_q.delay[0]) |=> s_q.alarm[0])
      else $error("type B low threshold run did not alarm");
   AST_TYPEB_HIGH: assert property (
      sample.valid && act_c[0] && s_q.cfg.type_b[0] && fhi_c[0] &&
      9'(s_q.cnt[0]) + 9'h001 >= 9'(s_q.delay[0]) |=> s_q.alarm[0])
      else $error("type B high threshold alarm missed");
   AST_LOW_MARGIN_OFF: assert property (
      s_q.lowp[0] == 10'h000 |-> !flo_c[0])
      else $error("low check active with margin off");
   AST_RUN_BREAK: assert property (
      sample.valid && !fault_c[0] |=> s_q.cnt[0] == 8'h00 && !s_q.alarm[0])
      else $error("passing sample did not clear run");
   AST_SETUP_TIMEOUT: assert property (
      setup_mode_active && !key_press &&
      s_q.idle_cnt == 30'(SETUP_TIMEOUT_CYC - 1) |=> !setup_mode_active)
      else $error("setup mode outlived its timeout");

   COV_ALARM_ONE: cover property ($rose(s_q.alarm[0]));
   COV_ALARM_TWO: cover property ($rose(s_q.alarm[1]));
   COV_TIMEOUT: cover property ($fell(setup_mode_active));
   COV_STATUS_CLEAR: cover property ($fell(s_q.sts[0]));

endmodule : hfm_monitor

`default_nettype wire

// file: test/hfm_load_model.sv
// Load current sensors and control outputs seen by the monitor
`timescale 1ns/1ns
`default_nettype none

module hfm_load_model (
   input wire logic aclk,
   input wire logic go,
   input wire logic [1:0][9:0] amps,
   input wire logic [1:0][9:0] level,
   input wire logic [1:0] on,
   output var hfm_pkg::hfm_sample_t sample
);
   // One sample per request; data flips between samples so stale
   // readings never look valid
   initial sample = '0;
   always @(posedge aclk) begin
      if (go) begin
         sample <= {1'b1, amps, level, on};
      end else begin
         sample <= {1'b0, ~sample[41:0]};
      end
   end
endmodule : hfm_load_model

`default_nettype wire

// file: test/heater_fault_current_monitor_bench.sv
// Register-driven bench for the heater fault current monitor
`timescale 1ns/1ns
`default_nettype none
`include "hfm_defs.svh"

module heater_fault_current_monitor_bench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   hfm_pkg::hfm_axi_req_t req = '0;
   hfm_pkg::hfm_axi_rsp_t rsp;
   hfm_pkg::hfm_sample_t sample;
   logic go = 1'b0;
   logic setup_enter = 1'b0;
   logic key_press = 1'b0;
   logic cont = 1'b0;
   logic [1:0][9:0] amps = '0;
   logic [1:0][9:0] level = {10'h000, 10'h1F4};
   logic [1:0] on = '0;
   logic al1, al2, setup, irq;
   logic [31:0] d;
   logic [1:0] r;
   int mismatches = 0;
   int check_count = 0;
   int lo, hi;
   logic [9:0] c0a [7] = '{10'h032, 10'h096, 10'h032, 10'h032,
      10'h063, 10'h064, 10'h064};
   logic [9:0] c1a [7] = '{10'h096, 10'h096, 10'h096, 10'h096,
      10'h063, 10'h063, 10'h064};
   logic [6:0] ona = 7'h0F;
   logic [6:0] e1 = 7'h48;
   logic [6:0] e2 = 7'h40;
   logic [9:0] cb [4] = '{10'h0C8, 10'h0C9, 10'h31F, 10'h320};

   // -------------------------------------------------------------
   // Clock, design and load model
   // -------------------------------------------------------------
   always #50 aclk = ~aclk;

   hfm_monitor #(.SETUP_TIMEOUT_CYC(20)) hfm_monitor_i (
      .aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
      .sample(sample), .out_one_continuous(cont),
      .setup_enter(setup_enter), .key_press(key_press),
      .heater_fault_alarm_one(al1), .heater_fault_alarm_two(al2),
      .setup_mode_active(setup), .irq(irq));

   hfm_load_model hfm_load_model_i (.aclk(aclk), .go(go), .amps(amps),
      .level(level), .on(on), .sample(sample));

   // -------------------------------------------------------------
   // Bus, sample and check tasks
   // -------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      bit aw, w;
      aw = 0;
      w = 0;
      @(posedge aclk);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= v;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      // Each channel is released at its own handshake
      while (!(aw && w)) begin
         @(posedge aclk);
         if (!aw && rsp.awready) begin
            aw = 1;
            req.awvalid <= 1'b0;
         end
         if (!w && rsp.wready) begin
            w = 1;
            req.wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (rsp.bvalid !== 1'b1);
      req.bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      do @(posedge aclk); while (rsp.arready !== 1'b1);
      req.arvalid <= 1'b0;
      do @(posedge aclk); while (rsp.rvalid !== 1'b1);
      d = rsp.rdata;
      r = rsp.rresp;
      req.rready <= 1'b0;
   endtask : rd

   task automatic fire(input logic [9:0] c0, c1, input logic o);
      @(posedge aclk);
      go <= 1'b1;
      amps <= {c1, c0};
      on <= {1'b0, o};
      @(posedge aclk);
      go <= 1'b0;
      // Model registers the sample, design takes it an edge later
      repeat (2) @(posedge aclk);
      #1;
   endtask : fire

   task automatic chk(input logic [31:0] s, e);
      check_count++;
      if (s !== e) begin
         mismatches++;
         $display("Error at %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk

   task automatic conclude();
      if (mismatches == 0 && check_count > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : conclude

   // Hang guard, well beyond the few hundred cycles of the tests
   initial begin
      repeat (4000) @(posedge aclk);
      mismatches++;
      conclude();
   end

   // -------------------------------------------------------------
   // Test sequence
   // -------------------------------------------------------------
   initial begin
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(`HFM_OFS_CONFIG);
      chk(d, 32'h00000001);
      rd(`HFM_OFS_DELAY);
      chk(d, 32'h00000303);
      rd(`HFM_OFS_MARGIN_ONE);
      chk(d, 32'h00000000);
      rd(8'h24);
      chk({30'h0, r}, 32'h00000002);
      // Type A, both sensors on output one, run lengths 2 and 1
      wr(`HFM_OFS_CONFIG, 32'h00000045);
      wr(`HFM_OFS_SETPOINT_ONE, 32'h00000064);
      wr(`HFM_OFS_SETPOINT_TWO, 32'h00000064);
      wr(`HFM_OFS_DELAY, 32'h00000102);
      wr(`HFM_OFS_MASK, 32'h00000003);
      for (int i = 0; i < 7; i++) begin
         fire(c0a[i], c1a[i], ona[i]);
         chk(al1, e1[i]);
         chk(al2, e2[i]);
      end
      chk(irq, 1'b1);
      rd(`HFM_OFS_STATUS);
      chk(d, 32'h00000003);
      wr(`HFM_OFS_STATUS, 32'h00000003);
      chk(irq, 1'b0);
      // Alarms stay set inside, yet no output fitted
      wr(`HFM_OFS_CONFIG, 32'h00000005);
      rd(`HFM_OFS_STATE);
      chk(d[1:0], 2'h3);
      chk({al1, al2}, 2'h0);
      // Type B on channel one, over-range setpoint clamps
      wr(`HFM_OFS_CONFIG, 32'h00000055);
      wr(`HFM_OFS_SETPOINT_ONE, 32'h000007FF);
      rd(`HFM_OFS_SETPOINT_ONE);
      chk(d, 32'h000003E8);
      rd(`HFM_OFS_MARGIN_ONE);
      chk(d, 32'h012C012C);
      wr(`HFM_OFS_DELAY, 32'h00000101);
      lo = 1000 * 500 / 1000 - 300 * 1000 / 1000;
      hi = 1000 * 500 / 1000 + 300 * 1000 / 1000;
      for (int i = 0; i < 4; i++) begin
         fire(cb[i], 10'h096, 1'b1);
         chk(al1, cb[i] <= lo || cb[i] >= hi);
      end
      wr(`HFM_OFS_MARGIN_ONE, 32'h00000000);
      fire(10'h000, 10'h096, 1'b1);
      chk(al1, 1'b0);
      fire(10'h3E8, 10'h096, 1'b1);
      chk(al1, 1'b0);
      wr(`HFM_OFS_CONFIG, 32'h00000041);
      rd(`HFM_OFS_SETPOINT_TWO);
      chk(d, 32'h00000000);
      // Channel two on output two (off), alarm routed to digital output
      wr(`HFM_OFS_CONFIG, 32'h00000089);
      fire(10'h096, 10'h096, 1'b1);
      chk(al2, 1'b1);
      chk(al1, 1'b1);
      // Setup mode, kept alive by a key, then left idle
      @(posedge aclk) setup_enter <= 1'b1;
      @(posedge aclk) setup_enter <= 1'b0;
      repeat (5) @(posedge aclk) key_press <= 1'b1;
      @(posedge aclk) key_press <= 1'b0;
      repeat (15) @(posedge aclk);
      #1 chk(setup, 1'b1);
      repeat (15) @(posedge aclk);
      #1 chk(setup, 1'b0);
      // Continuous output one strapped: channel one comes up as type B
      @(posedge aclk);
      cont <= 1'b1;
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (3) @(posedge aclk);
      rd(`HFM_OFS_CONFIG);
      chk(d, 32'h00000011);
      conclude();
   end
endmodule : heater_fault_current_monitor_bench

`default_nettype wire
